// ---- hw/watchdog_with_reset_sources.sv ----
// Watchdog timer with key control, time-out selection and reset sources
//
// What this block does
// R1 - Watchdog counter runs on low-speed oscillator ticks, divided 2^8 to 2^15.
// R2 - Time-out lasts 2^(8+n) low-speed ticks for three-bit select n.
// R3 - Key 10101 disables the watchdog, key 01010 enables it.
// R4 - Any other key forces full reset two to three ticks later, flag set.
// R5 - Key-fault flag set only by key fault, cleared only by software zero or power-on reset.
// R6 - Overflow while running resets device and sets time-out flag.
// R7 - Overflow while halted sets time-out flag, resets only PC and SP.
// R8 - Count cleared by key fault, reset pin low, clear command or halt.
// R9 - Software issues clear command before each overflow; key fault, pin reset and halt also clear.
// R10 - After power-on delay, device starts from program address zero.
// R11 - Power-on reset sets all port registers high, so pins are inputs.
// R12 - Low reset pin resets device, program counter returns to zero.
// R13 - After pin release, a further reset delay passes before running.
// R14 - Pin reset keeps some registers; only power-on forces everything.
// R15 - Halt with watchdog disabled clears the count and stops its clock.
// R16 - Binary up-counter; overflow when the selected bit falls from one to zero.
`timescale 1ns/1ps
`include "wdt_params.svh"
module watchdog_with_reset_sources
    import wdt_pkg::*;
#(
    parameter int unsigned LSO_DIV = `CLK_HZ / `LSO_HZ,
    parameter int unsigned POR_CYCLES = (`POR_DELAY_US / 1000) * (`CLK_HZ / 1000),
    parameter int unsigned PIN_CYCLES = (`PIN_DELAY_US / 100) * (`CLK_HZ / 10000)
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic external_reset_pin_n,
    input wire logic sleep_or_idle,
    output logic system_reset,
    output logic pc_sp_reset,
    output logic port_regs_high,
    output logic wdt_running,
    output logic irq
);
    wdt_state_t s_q;
    wdt_state_t s_d;
    logic acc;
    logic wr_ok;
    logic rd_ok;
    logic tick;
    logic [4:0] key;
    logic [2:0] sel;
    logic ovf;
    logic [15:0] cnt_next;
    logic [2:0] ev;
    logic key_bad;

    // Combinational next state
    always_comb begin
        s_d = s_q;
        // One-cycle wait state so reads always see registered data
        acc = (read || write) && s_q.waitreq;
        wr_ok = write && !s_q.waitreq;
        rd_ok = read && !s_q.waitreq;
        s_d.waitreq = !(read || write) || !s_q.waitreq;
        key = s_q.ctrl[7:`KEY_LSB];
        sel = s_q.ctrl[2:0];
        ev = '0;
        s_d.sys_reset = 1'b0;
        s_d.pc_sp_reset = 1'b0;
        // Low-speed tick enable from the core clock divider
        tick = 1'b0;
        if (s_q.lso_div >= LSO_DIV - 1) begin // see R1
            s_d.lso_div = '0;
            tick = 1'b1;
        end else begin
            s_d.lso_div = s_q.lso_div + 32'h1;
        end
        s_d.wdt_enabled = (key == `KEY_ENABLE); // see R3
        key_bad = (key != `KEY_ENABLE) && (key != `KEY_DISABLE);
        // Overflow when the selected counter bit falls back to zero
        cnt_next = s_q.count + 16'h1; // see R16
        ovf = 1'b0;
        if (tick && s_q.wdt_enabled && !s_q.clk_stop && s_q.st == ST_RUN) begin
            s_d.count = cnt_next;
            ovf = s_q.count[(`SEL_BASE - 1) + 32'(sel)] &&
                !cnt_next[(`SEL_BASE - 1) + 32'(sel)]; // see R2
        end
        if (ovf) begin
            s_d.count = '0;
            s_d.timeout_flag = 1'b1; // see R6, R7
            ev[`IRQ_TIMEOUT_BIT] = 1'b1;
            if (s_q.halted) begin
                s_d.pc_sp_reset = 1'b1; // see R7
                s_d.halted = 1'b0;
                s_d.clk_stop = 1'b0;
            end else begin
                s_d.sys_reset = 1'b1; // see R6
                s_d.power_down_flag = 1'b0;
            end
        end
        // Key fault counts off ticks before the full reset
        if (key_bad && !s_q.fault_pending) begin
            s_d.fault_pending = 1'b1;
            s_d.fault_wait = '0;
            s_d.count = '0; // see R8
        end
        if (s_q.fault_pending && tick) begin
            s_d.fault_wait = s_q.fault_wait + 2'h1;
            if (s_q.fault_wait == `KEY_FAULT_DELAY) begin // see R4
                s_d.fault_pending = 1'b0;
                s_d.sys_reset = 1'b1;
                s_d.key_fault_reset_flag = 1'b1; // see R5
                ev[`IRQ_KEYFAULT_BIT] = 1'b1;
                s_d.ctrl = `WDT_CTRL_RESET;
                s_d.count = '0;
                s_d.halted = 1'b0;
                s_d.clk_stop = 1'b0;
            end
        end
        // Register writes
        if (wr_ok) begin
            unique case (address)
                `ADDR_WDT_CTRL: begin
                    s_d.ctrl = writedata[7:0];
                end
                `ADDR_MODE_FLAGS: begin
                    // Software may only clear; a fault in the same cycle wins
                    if (!writedata[`WRF_BIT] && !ev[`IRQ_KEYFAULT_BIT])
                        s_d.key_fault_reset_flag = 1'b0; // see R5
                end
                `ADDR_CMD: begin
                    if (writedata[`CMD_CLR_BIT]) begin
                        s_d.count = '0; // see R8, R9
                        s_d.power_down_flag = 1'b0;
                        if (!ovf) s_d.timeout_flag = 1'b0;
                    end
                    if (writedata[`CMD_HALT_BIT] && sleep_or_idle) begin
                        s_d.count = '0; // see R8
                        s_d.halted = 1'b1;
                        s_d.power_down_flag = 1'b1;
                        if (!ovf) s_d.timeout_flag = 1'b0; // Overflow in same cycle wins
                        s_d.clk_stop = !s_q.wdt_enabled; // see R15
                    end
                end
                `ADDR_IRQ_MASK: begin
                    s_d.irq_mask = writedata[`IRQ_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
        // Reset pin and start-up sequencing
        unique case (s_q.st)
            ST_POR: begin
                s_d.sys_reset = 1'b1;
                s_d.ports_high = 1'b1; // see R11
                if (s_q.delay >= POR_CYCLES - 1) begin // see R10
                    s_d.st = ST_RUN;
                    s_d.delay = '0;
                    s_d.ports_high = 1'b0;
                end else begin
                    s_d.delay = s_q.delay + 32'h1;
                end
            end
            ST_RUN: begin
                if (!external_reset_pin_n) begin
                    s_d.st = ST_PIN_HOLD;
                end
            end
            ST_PIN_HOLD: begin
                s_d.sys_reset = 1'b1; // see R12
                s_d.count = '0; // see R8
                s_d.fault_pending = 1'b0;
                s_d.halted = 1'b0;
                s_d.clk_stop = 1'b0;
                s_d.ctrl = `WDT_CTRL_RESET; // see R14
                s_d.delay = '0;
                if (external_reset_pin_n) s_d.st = ST_PIN_DELAY;
            end
            ST_PIN_DELAY: begin
                s_d.sys_reset = 1'b1;
                if (!external_reset_pin_n) begin
                    s_d.st = ST_PIN_HOLD;
                end else if (s_q.delay >= PIN_CYCLES - 1) begin // see R13
                    s_d.st = ST_RUN;
                    ev[`IRQ_PINRESET_BIT] = 1'b1;
                end else begin
                    s_d.delay = s_q.delay + 32'h1;
                end
            end
            default: begin
                s_d.st = ST_POR;
            end
        endcase
        // Sticky status; clear only the bits that were read, new events win
        if (rd_ok && address == `ADDR_IRQ_STATUS)
            s_d.irq_status = (s_q.irq_status & ~s_q.rdata[`IRQ_WIDTH-1:0]) | ev;
        else
            s_d.irq_status = s_q.irq_status | ev;
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
        // Read data loaded when the request is first seen, so it stands at the take
        s_d.rdata = s_q.rdata;
        if (acc && read) begin
            s_d.rdata = '0;
            unique case (address)
                `ADDR_WDT_CTRL: s_d.rdata[7:0] = s_q.ctrl;
                `ADDR_MODE_FLAGS: s_d.rdata[`WRF_BIT] = s_q.key_fault_reset_flag;
                `ADDR_RESET_FLAGS: begin
                    s_d.rdata[`TO_BIT] = s_q.timeout_flag;
                    s_d.rdata[`PDF_BIT] = s_q.power_down_flag;
                end
                `ADDR_IRQ_STATUS: s_d.rdata[`IRQ_WIDTH-1:0] = s_q.irq_status;
                `ADDR_IRQ_MASK: s_d.rdata[`IRQ_WIDTH-1:0] = s_q.irq_mask;
                `ADDR_COUNT: s_d.rdata[`CNT_WIDTH-1:0] = s_q.count;
                default: s_d.rdata = '0;
            endcase
        end
    end

    // State register; power-on values under reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctrl <= `WDT_CTRL_RESET;
            s_q.st <= ST_POR;
            s_q.sys_reset <= 1'b1;
            s_q.ports_high <= 1'b1;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops; wdt_running ANDs two of them
    assign readdata = s_q.rdata;
    assign waitrequest = s_q.waitreq;
    assign system_reset = s_q.sys_reset;
    assign pc_sp_reset = s_q.pc_sp_reset;
    assign port_regs_high = s_q.ports_high;
    assign wdt_running = s_q.wdt_enabled && !s_q.clk_stop;
    assign irq = s_q.irq;
endmodule : watchdog_with_reset_sources

// ---- shared/wdt_params.svh ----
// Constants for the watchdog and reset-source block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define ADDR_WDT_CTRL 4'h0
`define ADDR_MODE_FLAGS 4'h1
`define ADDR_RESET_FLAGS 4'h2
`define ADDR_CMD 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_COUNT 4'h6
`define WDT_CTRL_RESET 8'h53
`define KEY_DISABLE 5'h15
`define KEY_ENABLE 5'h0A
`define KEY_LSB 3
`define SEL_BASE 8
`define KEY_FAULT_DELAY 2'h2
`define LSO_HZ 32000
`define CLK_HZ 100000000
`define POR_DELAY_US 50000
`define PIN_DELAY_US 16700
`define WRF_BIT 0
`define TO_BIT 0
`define PDF_BIT 1
`define CMD_CLR_BIT 0
`define CMD_HALT_BIT 1
`define IRQ_TIMEOUT_BIT 0
`define IRQ_KEYFAULT_BIT 1
`define IRQ_PINRESET_BIT 2
`define IRQ_WIDTH 3
`define CNT_WIDTH 16
`endif

// ---- shared/wdt_pkg.sv ----
// Types for the watchdog and reset-source block
package wdt_pkg;
    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_RUN = 4'h2,
        ST_PIN_HOLD = 4'h4,
        ST_PIN_DELAY = 4'h8
    } sys_state_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic key_fault_reset_flag;
        logic timeout_flag;
        logic power_down_flag;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [15:0] count;
        logic [31:0] lso_div;
        logic [1:0] fault_wait;
        logic fault_pending;
        logic [31:0] delay;
        sys_state_t st;
        logic halted;
        logic clk_stop;
        logic wdt_enabled;
        logic sys_reset;
        logic pc_sp_reset;
        logic ports_high;
        logic irq;
        logic [31:0] rdata;
        logic waitreq;
    } wdt_state_t;
endpackage : wdt_pkg

// ---- verification/tb_top.sv ----
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`include "wdt_params.svh"
module tb_top;
    logic core_clk = 0, rst = 1, read = 0, write = 0, pin_n = 1, sleep = 0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q, p;
    logic waitrequest, system_reset, pc_sp_reset, port_regs_high, wdt_running, irq;
    int n_errors = 0, n_tests = 0, c;
    localparam int OVF = 256 * 4; // Select 0 at four clocks per slow tick
    watchdog_with_reset_sources #(.LSO_DIV(4), .POR_CYCLES(20), .PIN_CYCLES(20)) dut_u (
        .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .external_reset_pin_n(pin_n), .sleep_or_idle(sleep), .system_reset(system_reset),
        .pc_sp_reset(pc_sp_reset), .port_regs_high(port_regs_high),
        .wdt_running(wdt_running), .irq(irq));
    // 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask : check
    // Avalon cycle; request held until the rising edge that sees waitrequest low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) n_errors++;
    endtask : bus
    task wr(input logic [3:0] a, input logic [31:0] d); bus(1, a, d); endtask : wr
    task rd(input logic [3:0] a); bus(0, a, 32'h0); endtask : rd
    // Cycles until the full reset reaches a level, capped at lim
    task wait_rst(input logic lvl, input int lim);
        c = 0;
        do begin @(posedge core_clk); c++; end while (system_reset !== lvl && c < lim);
    endtask : wait_rst
    task test_done;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // Cuts a hang short; the run needs about 4300 cycles
    initial begin
        #200000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 0;
        repeat (5) @(negedge core_clk);
        check("por", {system_reset, port_regs_high}, 2'b11);
        wait_rst(0, 40);
        check("por_end", port_regs_high, 0);
        wr(4'hF, 32'hFF);
        rd(4'hF); check("unmapped", q, 0);
        rd(`ADDR_WDT_CTRL); check("ctrl", q, `WDT_CTRL_RESET);
        rd(`ADDR_MODE_FLAGS); check("flags", q, 0);
        rd(`ADDR_COUNT); p = q;
        repeat (40) @(posedge core_clk);
        rd(`ADDR_COUNT); check("rate", (q - p) > 8 && (q - p) < 13, 1);
        // Periodic clears hold off the overflow; then it lands on time
        wr(`ADDR_IRQ_MASK, 0); wr(`ADDR_WDT_CTRL, 32'h50);
        repeat (3) begin
            wr(`ADDR_CMD, 1); wait_rst(1, 600); check("kept", c, 600);
        end
        wr(`ADDR_CMD, 1); wait_rst(1, 1200);
        check("ovf", c > OVF - 20 && c < OVF + 20, 1);
        wr(`ADDR_WDT_CTRL, 32'hA8);
        check("irq_masked", irq, 0);
        rd(`ADDR_RESET_FLAGS); check("to", q[0], 1);
        wr(`ADDR_IRQ_MASK, 7); repeat (2) @(negedge core_clk); check("irq_on", irq, 1);
        rd(`ADDR_IRQ_STATUS); check("irq_st", q[0], 1);
        repeat (2) @(negedge core_clk); check("irq_off", irq, 0);
        wr(`ADDR_CMD, 1); rd(`ADDR_RESET_FLAGS); check("clr", q, 0);
        // Halt with the watchdog running: overflow resets PC and SP only
        sleep <= 1; wr(`ADDR_WDT_CTRL, 32'h50); wr(`ADDR_CMD, 2);
        rd(`ADDR_RESET_FLAGS); check("pdf", q, 2);
        c = 0;
        do begin @(negedge core_clk); c++; end while (pc_sp_reset !== 1'b1 && c < 1200);
        check("pcsp", c < 1200, 1);
        rd(`ADDR_RESET_FLAGS); check("to_halt", q, 3);
        // Halt with the watchdog off stops the count at zero
        wr(`ADDR_WDT_CTRL, 32'hA8); wr(`ADDR_CMD, 2);
        rd(`ADDR_COUNT); check("cnt0", q, 0);
        repeat (40) @(posedge core_clk);
        rd(`ADDR_COUNT); check("cnt_hold", q, 0);
        sleep <= 0;
        // A bad key forces a delayed full reset and sets its flag
        wr(`ADDR_WDT_CTRL, 32'hF8); wait_rst(1, 40);
        check("fault", c > 5 && c < 20, 1);
        wait_rst(0, 10);
        rd(`ADDR_MODE_FLAGS); check("wrf", q, 1);
        rd(`ADDR_IRQ_STATUS); check("irq_kf", q[1], 1);
        // Pin reset, then a further delay after release; flag kept
        wr(`ADDR_WDT_CTRL, 32'h51);
        pin_n <= 0; wait_rst(1, 5); check("pin", c < 5, 1);
        @(posedge core_clk); pin_n <= 1;
        wait_rst(0, 60); check("pin_delay", c > 15 && c < 30, 1);
        rd(`ADDR_MODE_FLAGS); check("kept_flag", q, 1);
        rd(`ADDR_WDT_CTRL); check("ctrl_pin", q, `WDT_CTRL_RESET);
        rd(`ADDR_COUNT); check("cnt_pin", q < 32'd20, 1);
        rd(`ADDR_IRQ_STATUS); check("irq_pin", q[2], 1);
        wr(`ADDR_MODE_FLAGS, 1); rd(`ADDR_MODE_FLAGS); check("wrf_set", q, 1);
        wr(`ADDR_MODE_FLAGS, 0); rd(`ADDR_MODE_FLAGS); check("wrf_clr", q, 0);
        test_done;
    end
endmodule : tb_top

// ---- verification/wdt_properties.sv ----
// Port checker for the watchdog block
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_properties #(
    parameter int PIN_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic external_reset_pin_n,
    input wire logic system_reset,
    input wire logic pc_sp_reset,
    input wire logic port_regs_high,
    input wire logic wdt_running,
    input wire logic irq
);
    // Window for the end of the pin delay, loose by a few sync stages
    localparam int PIN_LO = PIN_CYCLES - 10;
    localparam int PIN_HI = PIN_CYCLES + 6;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // A control write that the slave accepts
    wire logic wr_ctrl = write && !waitrequest && address == `ADDR_WDT_CTRL;
    wire logic [4:0] key = writedata[7:3];
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("answer too long");
    a_rst_state: assert property (disable iff (1'b0) rst |=> system_reset && port_regs_high
        && waitrequest && !irq) else $error("reset outputs wrong");
    a_por_hold: assert property ($fell(rst) |-> (system_reset && port_regs_high) [*8])
        else $error("power-on window short");
    a_pin_reset: assert property (!external_reset_pin_n |-> ##[0:2] system_reset)
        else $error("pin low without reset");
    a_pin_delay: assert property ($rose(external_reset_pin_n) |-> system_reset [*8]
        ##[PIN_LO:PIN_HI] !system_reset) else $error("pin delay wrong");
    a_key_off: assert property (wr_ctrl && key == `KEY_DISABLE |-> ##[1:2] !wdt_running)
        else $error("disable key ignored");
    a_key_on: assert property (wr_ctrl && key == `KEY_ENABLE |-> ##[1:2] wdt_running)
        else $error("enable key ignored");
    a_fault_delay: assert property (wr_ctrl && key != `KEY_ENABLE && key != `KEY_DISABLE
        |=> !system_reset [*4] ##[1:14] system_reset) else $error("key fault timing");
    a_pcsp_pulse: assert property (pc_sp_reset |-> !system_reset ##1 !pc_sp_reset)
        else $error("partial reset wrong");
endmodule : wdt_properties

bind watchdog_with_reset_sources wdt_properties #(.PIN_CYCLES(PIN_CYCLES)) chk_u (
    .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .waitrequest(waitrequest),
    .external_reset_pin_n(external_reset_pin_n), .system_reset(system_reset),
    .pc_sp_reset(pc_sp_reset), .port_regs_high(port_regs_high),
    .wdt_running(wdt_running), .irq(irq));
